// *** design/lane_err_pkg.sv ***
package lane_err_pkg;
    localparam int num_lanes = 8;
    localparam int num_types = 3;
    localparam int count_w = 8;
    localparam int paddr_w = 14;
    // register indices; the byte address is four times the index
    localparam logic [11:0] idx_error_window = 12'h46b;
    localparam logic [11:0] idx_lane_align = 12'h46c;
    localparam logic [11:0] idx_event_status = 12'h480;
    localparam logic [11:0] idx_event_mask = 12'h481;
    localparam logic [11:0] idx_link_control = 12'h482;
    // window fields
    localparam int lane_sel_lsb = 4;
    localparam int lane_sel_msb = 6;
    localparam int type_sel_lsb = 0;
    localparam int type_sel_msb = 1;
    localparam logic [1:0] type_disparity = 2'h0;
    localparam logic [1:0] type_invalid = 2'h1;
    localparam logic [1:0] type_control = 2'h2;
    localparam logic [1:0] type_unused = 2'h3;
    localparam logic [7:0] lane_align_reset = 8'h0f;
    localparam int half_lanes = 4;
    // event status and mask layout
    localparam int event_w = 3;
    localparam int ev_disparity = 0;
    localparam int ev_invalid = 1;
    localparam int ev_control = 2;
    localparam int dual_link_bit = 0;
    localparam logic [count_w-1:0] count_max = 8'hff;
endpackage

// *** design/counter_sel_if.sv ***
interface counter_sel_if;
    logic [2:0] lane;
    logic [1:0] ctype;
    logic [7:0] count;
    modport reg_side (output lane, output ctype, input count);
    modport cnt_side (input lane, input ctype, output count);
endinterface

// *** design/lane_error_counters.sv ***
module lane_error_counters (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] disparity_err,
    input wire logic [7:0] invalid_err,
    input wire logic [7:0] control_err,
    counter_sel_if.cnt_side sel
);
    // ==========================================================
    // state
    typedef struct packed {
        logic [lane_err_pkg::num_types-1:0][lane_err_pkg::num_lanes-1:0][lane_err_pkg::count_w-1:0] cnt;
    } cnt_state_t;

    cnt_state_t s;
    cnt_state_t next_s;

    function automatic logic [7:0] sat_inc(input logic [7:0] v, input logic hit);
        sat_inc = (hit && v != lane_err_pkg::count_max) ? v + 8'h01 : v;
    endfunction

    // ==========================================================
    // counting
    always_comb begin
        next_s = s;
        for (int l = 0; l < lane_err_pkg::num_lanes; l++) begin
            next_s.cnt[lane_err_pkg::type_disparity][l] = sat_inc(s.cnt[lane_err_pkg::type_disparity][l],
                disparity_err[l]); // see R7
            next_s.cnt[lane_err_pkg::type_invalid][l] = sat_inc(s.cnt[lane_err_pkg::type_invalid][l],
                invalid_err[l]); // see R7
            next_s.cnt[lane_err_pkg::type_control][l] = sat_inc(s.cnt[lane_err_pkg::type_control][l],
                control_err[l]); // see R7
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // unused type code reads as zero
    assign sel.count = (sel.ctype == lane_err_pkg::type_unused) ? 8'h00 : s.cnt[sel.ctype][sel.lane]; // see R8

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_count_step;
        ce && disparity_err[0] && s.cnt[0][0] != lane_err_pkg::count_max |=> s.cnt[0][0] == $past(s.cnt[0][0]) + 8'h01;
    endproperty
    a_count_step: assert property (p_count_step) else $error("error counter did not step"); // see R7

    property p_count_hold;
        !ce |=> $stable(s.cnt);
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("counters moved with clock enable low"); // see R7

    property p_unused_zero;
        sel.ctype == lane_err_pkg::type_unused |-> sel.count == 8'h00;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused counter type not zero"); // see R8

    c_saturate: cover property (s.cnt[1][3] == lane_err_pkg::count_max);
endmodule // lane_error_counters

// *** design/lane_error_monitor.sv ***
// How it works
// R1: two-bit type select picks counter kind
// R2: three-bit lane select picks readback lane
// R3: readback returns count of selected lane, type
// R4: software writes selects before reading count
// R5: deskew enable register resets to lanes 0-3
// R6: dual link uses low four bits per link
// R7: three counters per lane, reached indirectly
// R8: type three reads zero, counters untouched
//
// The APB slave port was left to the implementer.
module lane_error_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] disparity_err,
    input wire logic [7:0] invalid_err,
    input wire logic [7:0] control_err,
    output logic [7:0] deskew_lane_en,
    output logic irq
);
    // ==========================================================
    // state
    typedef struct packed {
        logic [2:0] lane_sel;
        logic [1:0] type_sel;
        logic [7:0] align;
        logic [lane_err_pkg::event_w-1:0] status;
        logic [lane_err_pkg::event_w-1:0] mask;
        logic dual;
        logic primed;
        logic err;
        logic [31:0] rdata;
    } mon_state_t;

    mon_state_t s;
    mon_state_t next_s;
    logic [lane_err_pkg::event_w-1:0] events;
    logic access;

    counter_sel_if csel ();

    lane_error_counters counters (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .disparity_err(disparity_err),
        .invalid_err(invalid_err),
        .control_err(control_err),
        .sel(csel)
    );

    function automatic logic hit(input logic [13:0] a, input logic [11:0] idx);
        hit = (a == {idx, 2'b00});
    endfunction

    function automatic logic mapped(input logic [13:0] a);
        mapped = hit(a, lane_err_pkg::idx_error_window) || hit(a, lane_err_pkg::idx_lane_align) ||
                 hit(a, lane_err_pkg::idx_event_status) || hit(a, lane_err_pkg::idx_event_mask) ||
                 hit(a, lane_err_pkg::idx_link_control);
    endfunction

    assign csel.lane = s.lane_sel; // see R2
    assign csel.ctype = s.type_sel; // see R1

    // one driver for the whole event vector
    always_comb begin
        events = '0;
        events[lane_err_pkg::ev_disparity] = |disparity_err;
        events[lane_err_pkg::ev_invalid] = |invalid_err;
        events[lane_err_pkg::ev_control] = |control_err;
    end

    // ==========================================================
    // bus and registers
    // read data is captured in the setup cycle and answered in the first access cycle
    assign access = psel && penable && ce && s.primed;

    always_comb begin
        next_s = s;
        next_s.status = s.status | events;
        if (psel && !s.primed) begin
            next_s.primed = 1'b1;
            next_s.err = !mapped(paddr);
            next_s.rdata = 32'h00000000;
            if (hit(paddr, lane_err_pkg::idx_error_window)) begin
                next_s.rdata[7:0] = csel.count; // see R3
            end else if (hit(paddr, lane_err_pkg::idx_lane_align)) begin
                next_s.rdata[7:0] = s.align;
            end else if (hit(paddr, lane_err_pkg::idx_event_status)) begin
                next_s.rdata[lane_err_pkg::event_w-1:0] = s.status;
            end else if (hit(paddr, lane_err_pkg::idx_event_mask)) begin
                next_s.rdata[lane_err_pkg::event_w-1:0] = s.mask;
            end else if (hit(paddr, lane_err_pkg::idx_link_control)) begin
                next_s.rdata[lane_err_pkg::dual_link_bit] = s.dual;
            end
        end
        if (access) begin
            next_s.primed = 1'b0;
            if (pwrite) begin
                if (hit(paddr, lane_err_pkg::idx_error_window)) begin
                    next_s.lane_sel = pwdata[lane_err_pkg::lane_sel_msb:lane_err_pkg::lane_sel_lsb]; // see R2
                    next_s.type_sel = pwdata[lane_err_pkg::type_sel_msb:lane_err_pkg::type_sel_lsb]; // see R1
                end
                if (hit(paddr, lane_err_pkg::idx_lane_align)) begin
                    next_s.align = pwdata[7:0]; // see R5
                end
                if (hit(paddr, lane_err_pkg::idx_event_status)) begin
                    // new events win over the write-one clear
                    next_s.status = (s.status & ~pwdata[lane_err_pkg::event_w-1:0]) | events;
                end
                if (hit(paddr, lane_err_pkg::idx_event_mask)) begin
                    next_s.mask = pwdata[lane_err_pkg::event_w-1:0];
                end
                if (hit(paddr, lane_err_pkg::idx_link_control)) begin
                    next_s.dual = pwdata[lane_err_pkg::dual_link_bit];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
            s.align <= lane_err_pkg::lane_align_reset; // see R5
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign pready = access;
    assign pslverr = access && s.err;
    assign prdata = s.rdata;
    assign irq = |(s.status & s.mask);

    // ==========================================================
    // deskew enables
    always_comb begin
        if (s.dual) begin
            // each link takes the low four bits for its own four lanes
            deskew_lane_en = {s.align[lane_err_pkg::half_lanes-1:0], s.align[lane_err_pkg::half_lanes-1:0]}; // see R6
        end else begin
            deskew_lane_en = s.align; // see R5
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_align_reset;
        $fell(rst) |-> s.align == lane_err_pkg::lane_align_reset && deskew_lane_en == lane_err_pkg::lane_align_reset;
    endproperty
    a_align_reset: assert property (p_align_reset) else $error("deskew enable reset value wrong"); // see R5

    // a deskew write in dual link mode shows up on both halves
    property p_dual_split;
        access && pwrite && s.dual && hit(paddr, lane_err_pkg::idx_lane_align) |=>
            deskew_lane_en == {2{$past(pwdata[lane_err_pkg::half_lanes-1:0])}};
    endproperty
    a_dual_split: assert property (p_dual_split) else $error("dual link deskew split wrong"); // see R6

    property p_single_pass;
        access && pwrite && !s.dual && hit(paddr, lane_err_pkg::idx_lane_align) |=>
            deskew_lane_en == $past(pwdata[7:0]);
    endproperty
    a_single_pass: assert property (p_single_pass) else $error("single link deskew mismatch"); // see R6

    property p_sel_write;
        access && pwrite && hit(paddr, lane_err_pkg::idx_error_window) |=>
            s.lane_sel == $past(pwdata[6:4]) && s.type_sel == $past(pwdata[1:0]);
    endproperty
    a_sel_write: assert property (p_sel_write) else $error("select fields not stored"); // see R1

    property p_readback;
        psel && !penable && ce && !s.primed && !pwrite && hit(paddr, lane_err_pkg::idx_error_window) |=>
            prdata == {24'h000000, $past(csel.count)} && (pready || !(psel && penable && ce));
    endproperty
    a_readback: assert property (p_readback) else $error("window readback wrong"); // see R3

    property p_lane_route;
        // selects move only on a window write
        !(access && pwrite && hit(paddr, lane_err_pkg::idx_error_window)) |=>
            $stable(csel.lane) && $stable(csel.ctype);
    endproperty
    a_lane_route: assert property (p_lane_route) else $error("lane select not routed"); // see R2

    property p_unused_read;
        psel && !penable && ce && !s.primed && s.type_sel == lane_err_pkg::type_unused &&
            hit(paddr, lane_err_pkg::idx_error_window) |=> prdata == 32'h00000000;
    endproperty
    a_unused_read: assert property (p_unused_read) else $error("unused type read not zero"); // see R8

    property p_sticky;
        ce && s.status[0] && !(access && pwrite && hit(paddr, lane_err_pkg::idx_event_status)) |=> s.status[0];
    endproperty
    a_sticky: assert property (p_sticky) else $error("status bit lost"); // see R7

    property p_irq;
        ce && (|invalid_err) && s.mask[lane_err_pkg::ev_invalid] &&
            !(access && pwrite && hit(paddr, lane_err_pkg::idx_event_mask)) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt level wrong");

    // an event wins over a write-one clear in the same cycle
    property p_status_set;
        ce && events[lane_err_pkg::ev_invalid] |=> s.status[lane_err_pkg::ev_invalid];
    endproperty
    a_status_set: assert property (p_status_set) else $error("event lost against clear");

    property p_unmapped;
        psel && !penable && ce && !s.primed && !mapped(paddr) |=>
            prdata == 32'h00000000 && pslverr == pready;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

    property p_ce_freeze;
        !ce |=> $stable(s);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze) else $error("register state moved with clock enable low");

    c_window_read: cover property (access && !pwrite && hit(paddr, lane_err_pkg::idx_error_window) && prdata != 0);
    c_dual: cover property (s.dual && s.align[3:0] != 4'h0);
    c_irq: cover property ($rose(irq));
endmodule // lane_error_monitor

// *** tb/lane_error_counter_access_deskew_test.sv ***
module lane_error_counter_access_deskew_test;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // stimulus and design
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [13:0] paddr = 14'h0000;
    logic [31:0] pwdata = 32'h00000000;
    logic [7:0] ev [3] = '{8'h00, 8'h00, 8'h00};
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] deskew_lane_en;
    logic irq;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    int cnt [3][8];
    logic [2:0] st = 3'h0;
    logic [31:0] rnd = 32'h0000443c;

    always #20 clk = ~clk;

    lane_error_monitor DUT (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .disparity_err(ev[0]),
        .invalid_err(ev[1]),
        .control_err(ev[2]),
        .deskew_lane_en(deskew_lane_en),
        .irq(irq)
    );

    // ==========================================================
    // reference model: saturating counters and sticky status
    always @(posedge clk) begin
        if (rst) begin
            foreach (cnt[t, l]) cnt[t][l] = 0;
            st = 3'h0;
        end else if (ce === 1'b1) begin
            for (int t = 0; t < 3; t++) begin
                for (int l = 0; l < 8; l++) begin
                    if (ev[t][l] && cnt[t][l] < 255) cnt[t][l]++;
                end
                if (ev[t] != 8'h00) st[t] = 1'b1;
            end
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            failures++;
            report_and_stop();
        end
    end

    // ==========================================================
    // helpers
    function automatic logic [31:0] next_rand(input logic [31:0] v);
        logic [31:0] x;
        x = v;
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    task automatic report_and_stop();
        if (failures == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            failures++;
        end
    endtask

    task automatic xfer(input logic w, input logic [11:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd, output logic sl);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        sl = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        logic [31:0] rd;
        logic sl;
        logic [7:0] a;
        int exp;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("deskew_lane_en", 32'h0000000f, {24'h0, deskew_lane_en});
        xfer(1'b0, lane_err_pkg::idx_lane_align, 32'h0, rd, sl);
        chk("lane_align_enable", 32'h0000000f, rd);
        for (int r = 0; r < 2; r++) begin
            repeat (300) begin
                @(posedge clk);
                rnd = next_rand(rnd);
                ce <= rnd[0] | rnd[1];
                ev[0] <= rnd[15:8];
                ev[1] <= rnd[23:16];
                ev[2] <= rnd[31:24];
            end
            @(posedge clk);
            ce <= 1'b1;
            ev <= '{8'h00, 8'h00, 8'h00};
            for (int l = 0; l < 8; l++) begin
                for (int t = 0; t < 4; t++) begin
                    xfer(1'b1, lane_err_pkg::idx_error_window, {25'h0, 3'(l), 2'h0, 2'(t)}, rd, sl);
                    xfer(1'b0, lane_err_pkg::idx_error_window, 32'h0, rd, sl);
                    exp = (t == 3) ? 0 : cnt[t][l];
                    chk("counter_readback", 32'(exp), rd);
                    chk("pslverr", 32'h0, {31'h0, sl});
                end
            end
        end
        repeat (4) begin
            rnd = next_rand(rnd);
            a = rnd[7:0];
            xfer(1'b1, lane_err_pkg::idx_lane_align, {24'h0, a}, rd, sl);
            xfer(1'b0, lane_err_pkg::idx_lane_align, 32'h0, rd, sl);
            chk("lane_align_enable", {24'h0, a}, rd);
            xfer(1'b1, lane_err_pkg::idx_link_control, {31'h0, rnd[8]}, rd, sl);
            @(negedge clk);
            chk("deskew_lane_en", {24'h0, rnd[8] ? {a[3:0], a[3:0]} : a}, {24'h0, deskew_lane_en});
        end
        xfer(1'b0, lane_err_pkg::idx_event_status, 32'h0, rd, sl);
        chk("event_status", {29'h0, st}, rd);
        chk("irq masked", 32'h0, {31'h0, irq});
        xfer(1'b1, lane_err_pkg::idx_event_mask, 32'h00000007, rd, sl);
        @(negedge clk);
        chk("irq unmasked", {31'h0, st != 3'h0}, {31'h0, irq});
        // an event in the clearing cycle must survive the write-one clear
        @(posedge clk);
        ev[1] <= 8'h01;
        xfer(1'b1, lane_err_pkg::idx_event_status, 32'h00000007, rd, sl);
        ev[1] <= 8'h00;
        xfer(1'b0, lane_err_pkg::idx_event_status, 32'h0, rd, sl);
        chk("event_status set wins", 32'h00000002, rd);
        chk("irq set wins", 32'h1, {31'h0, irq});
        xfer(1'b1, lane_err_pkg::idx_event_status, 32'h00000007, rd, sl);
        @(negedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        xfer(1'b0, lane_err_pkg::idx_event_status, 32'h0, rd, sl);
        chk("event_status cleared", 32'h0, rd);
        xfer(1'b0, 12'h000, 32'h0, rd, sl);
        chk("unmapped pslverr", 32'h1, {31'h0, sl});
        chk("unmapped prdata", 32'h0, rd);
        report_and_stop();
    end
endmodule // lane_error_counter_access_deskew_test
